// File: asd_regs.svh
`ifndef ASD_REGS_SVH
`define ASD_REGS_SVH

// ----------------------------------------------------------------
// register byte offsets on the avalon slave
// ----------------------------------------------------------------
`define ASD_OFF_DAC_CFG   8'h00
`define ASD_OFF_ADC_CFG   8'h04
`define ASD_OFF_GPO_CFG   8'h08
`define ASD_OFF_GP_CTRL   8'h0C
`define ASD_OFF_DEFER     8'h10
`define ASD_OFF_SEQ       8'h14
`define ASD_OFF_GPO_DATA  8'h18
`define ASD_OFF_GPI_DATA  8'h1C
`define ASD_OFF_STATUS    8'h60
`define ASD_OFF_RESULT    8'h64
// dac input registers 0x20..0x3C, dac outputs 0x40..0x5C
`define ASD_DACIN_PAGE    3'h1
`define ASD_DACOUT_PAGE   3'h2

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define ASD_GP_DAC_GAIN   4
`define ASD_GP_ADC_RANGE  5
`define ASD_GP_BUSY_EN    8
`define ASD_DEFER_MODE    0
`define ASD_DEFER_LOAD    1
`define ASD_FRAME_DAC     15
`define ASD_ST_CONV       0
`define ASD_ST_VALID      1
`define ASD_ST_TRACK      2
`define ASD_ST_MUX_LSB    4

// ----------------------------------------------------------------
// framing and timing
// ----------------------------------------------------------------
`define ASD_FRAME_BITS    5'd16
`define ASD_BUSY_CHAN     7
`define ASD_CLK_PERIOD_NS 10
`define ASD_CONV_TIME_NS  2000
`define ASD_CONV_CYCLES   ((`ASD_CONV_TIME_NS + `ASD_CLK_PERIOD_NS - 1) / `ASD_CLK_PERIOD_NS)

`endif

// File: asd_pkg.sv
package asd_pkg;

  // sequencer phases
  typedef enum logic [1:0] {
    SEQ_IDLE,
    SEQ_TRACK,
    SEQ_CONVERT
  } asd_seq_state_t;

endpackage : asd_pkg

// File: asd_sync.sv
`timescale 1ns/1ps

// ----------------------------------------------------------------
// two-stage synchroniser, one stage pair per bit
// ----------------------------------------------------------------
module asd_sync #(
  parameter int WIDTH = 11
) (
  input  wire logic             ref_clk,
  input  wire logic             srst,
  input  wire logic [WIDTH-1:0] asyncIn,
  output logic      [WIDTH-1:0] syncOut
);

  logic [WIDTH-1:0] meta_r;

  // first stage feeds only the second stage
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      meta_r  <= '0;
      syncOut <= '0;
    end else begin
      meta_r  <= asyncIn;
      syncOut <= meta_r;
    end
  end

endmodule : asd_sync

// File: asd_ctrl.sv
`timescale 1ns/1ps
`include "asd_regs.svh"

// Notes on behaviour
// - each of eight pins is dac out, adc in, digital in or out
// - one dac gain bit picks 1x or 2x span for all channels
// - dac codes are 12-bit straight binary, 0 to 4095
// - without deferral a dac output follows its input register write
// - deferred load holds dac outputs until a load command applies all
// - channels to convert come from a sequence register write
// - after the sequence write the first selected channel tracks
// - first frame-select fall after sequence write converts first channel
// - later falls convert next channel and shift out previous result
// - mux advances to next selected channel, skipping unselected ones
// - result frame: zero, three address bits, twelve data bits
// - conversion lasts 2 us; host never starts one early
// - busy on pin seven is low converting, high with result ready
// - bit 5 of general control picks adc span for all inputs
// - adc results are 12-bit straight binary
// - pin both dac and adc keeps driving dac, may be converted
// - frame select active low; 16 falling clocks captured after it
// - serial input sampled on falling serial clock edges
// - hold at frame-select fall, back to track when done
module asd_ctrl (
  input  wire logic         ref_clk,
  input  wire logic         srst,
  input  wire logic [7:0]   avs_address,
  input  wire logic         avs_read,
  input  wire logic         avs_write,
  input  wire logic [31:0]  avs_writedata,
  output logic      [31:0]  avs_readdata,
  output logic              avs_waitrequest,
  input  wire logic         sclk,
  input  wire logic         frameSelN,
  input  wire logic         sdi,
  output logic              sdo,
  input  wire logic [11:0]  adcData,
  output logic      [2:0]   muxSel,
  output logic              trackMode,
  output logic              adcRange,
  output logic              dacGain,
  output logic      [7:0]   dacEnable,
  output logic      [7:0]   adcEnable,
  output logic      [95:0]  dacCode,
  input  wire logic [7:0]   pinIn,
  output logic      [7:0]   pinOut,
  output logic      [7:0]   pinOeN
);

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  logic [7:0]        dacMask_r;
  logic [7:0]        adcMask_r;
  logic [7:0]        gpoMask_r;
  logic [7:0]        gpoData_r;
  logic              busyEn_r;
  logic              deferMode_r;
  logic              loadAll_r;
  logic [7:0]        seqMask_r;
  logic [7:0][11:0]  dacIn_r;
  logic [7:0][11:0]  dacOut_r;
  logic [7:0]        dacWrStb_r;
  logic              waitReq_r;
  logic [31:0]       rdData_r;
  logic [10:0]       syncBits;
  logic              sclkS;
  logic              frameSelNS;
  logic              sdiS;
  logic [7:0]        pinS;
  logic              sclkD_r;
  logic              frameSelND_r;
  logic [4:0]        bitCnt_r;
  logic [15:0]       rxShift_r;
  logic              frameDone_r;
  logic [15:0]       txShift_r;
  asd_pkg::asd_seq_state_t state_r;
  logic [7:0]        timer_r;
  logic [2:0]        convChan_r;
  logic [15:0]       result_r;
  logic              resultValid_r;
  logic              busy_r;
  logic [2:0]        muxSel_r;
  logic              track_r;
  logic [7:0]        pinOut_r;
  logic [7:0]        pinOeN_r;

  // ----------------------------------------------------------------
  // next selected channel, searching upward from start with wrap
  // ----------------------------------------------------------------
  function automatic logic [2:0] asdNextChan(input logic [7:0] mask,
                                             input logic [2:0] start);
    logic [2:0] idx;
    logic [2:0] res;
    logic       found;
    res   = start;
    found = 1'b0;
    for (int k = 0; k < 8; k++) begin
      idx = start + 3'(k);
      if (!found && mask[idx]) begin
        res   = idx;
        found = 1'b1;
      end
    end
    return res;
  endfunction : asdNextChan

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  asd_sync #(
    .WIDTH   (11)
  ) u_sync (
    .ref_clk (ref_clk),
    .srst    (srst),
    .asyncIn ({pinIn, sdi, frameSelN, sclk}),
    .syncOut (syncBits)
  );

  assign sclkS      = syncBits[0];
  assign frameSelNS = syncBits[1];
  assign sdiS       = syncBits[2];
  assign pinS       = syncBits[10:3];

  // ----------------------------------------------------------------
  // avalon decode; one wait state on every access
  // ----------------------------------------------------------------
  wire        busReq   = avs_read | avs_write;
  wire        busAck   = busReq & ~waitReq_r;
  wire        wrAck    = avs_write & busAck;
  wire        selDacCfg = avs_address == `ASD_OFF_DAC_CFG;
  wire        selAdcCfg = avs_address == `ASD_OFF_ADC_CFG;
  wire        selGpoCfg = avs_address == `ASD_OFF_GPO_CFG;
  wire        selGpCtrl = avs_address == `ASD_OFF_GP_CTRL;
  wire        selDefer  = avs_address == `ASD_OFF_DEFER;
  wire        selSeq    = avs_address == `ASD_OFF_SEQ;
  wire        selGpoDat = avs_address == `ASD_OFF_GPO_DATA;
  wire        selGpiDat = avs_address == `ASD_OFF_GPI_DATA;
  wire        selStatus = avs_address == `ASD_OFF_STATUS;
  wire        selResult = avs_address == `ASD_OFF_RESULT;
  wire        aligned   = avs_address[1:0] == 2'h0;
  wire        selDacIn  = aligned && avs_address[7:5] == `ASD_DACIN_PAGE;
  wire        selDacOut = aligned && avs_address[7:5] == `ASD_DACOUT_PAGE;
  wire [2:0]  regChan   = avs_address[4:2];
  wire        seqWr     = wrAck & selSeq;
  wire [7:0]  gpiMask   = ~(dacMask_r | adcMask_r | gpoMask_r);
  wire [31:0] statusWord = {25'h0, muxSel_r, 1'b0, track_r,
                            resultValid_r, state_r == asd_pkg::SEQ_CONVERT};

  // read mux; unmapped addresses read as zero
  wire [31:0] rdMux =
    selDacCfg ? {24'h0, dacMask_r} :
    selAdcCfg ? {24'h0, adcMask_r} :
    selGpoCfg ? {24'h0, gpoMask_r} :
    selGpCtrl ? {23'h0, busyEn_r, 2'h0, adcRange, dacGain, 4'h0} :
    selDefer  ? {31'h0, deferMode_r} :
    selSeq    ? {24'h0, seqMask_r} :
    selGpoDat ? {24'h0, gpoData_r} :
    selGpiDat ? {24'h0, pinS & gpiMask} :
    selStatus ? statusWord :
    selResult ? {16'h0, result_r} :
    selDacIn  ? {20'h0, dacIn_r[regChan]} :
    selDacOut ? {20'h0, dacOut_r[regChan]} :
    32'h0;

  // waitrequest drops for exactly one cycle per request
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      waitReq_r <= 1'b1;
      rdData_r  <= 32'h0;
    end else begin
      waitReq_r <= ~(busReq & waitReq_r);
      if (busReq & waitReq_r) rdData_r <= rdMux;
    end
  end

  assign avs_waitrequest = waitReq_r;
  assign avs_readdata    = rdData_r;

  // ----------------------------------------------------------------
  // configuration registers
  // ----------------------------------------------------------------
  // the shared gain and range bits are single flops, so no per-channel
  // span can exist
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      dacMask_r   <= 8'h00;
      adcMask_r   <= 8'h00;
      gpoMask_r   <= 8'h00;
      gpoData_r   <= 8'h00;
      busyEn_r    <= 1'b0;
      dacGain     <= 1'b0;
      adcRange    <= 1'b0;
      deferMode_r <= 1'b0;
      loadAll_r   <= 1'b0;
    end else begin
      loadAll_r <= 1'b0;
      if (wrAck) begin
        if (selDacCfg) dacMask_r <= avs_writedata[7:0];
        if (selAdcCfg) adcMask_r <= avs_writedata[7:0];
        if (selGpoCfg) gpoMask_r <= avs_writedata[7:0];
        if (selGpoDat) gpoData_r <= avs_writedata[7:0];
        if (selGpCtrl) begin
          dacGain  <= avs_writedata[`ASD_GP_DAC_GAIN];
          adcRange <= avs_writedata[`ASD_GP_ADC_RANGE];
          busyEn_r <= avs_writedata[`ASD_GP_BUSY_EN];
        end
        if (selDefer) begin
          deferMode_r <= avs_writedata[`ASD_DEFER_MODE];
          loadAll_r   <= avs_writedata[`ASD_DEFER_LOAD];
        end
      end
    end
  end

  assign dacEnable = dacMask_r;
  assign adcEnable = adcMask_r;

  // ----------------------------------------------------------------
  // serial receive: 16 bits on falling sclk after frame select falls
  // ----------------------------------------------------------------
  wire sclkFall  = sclkD_r & ~sclkS;
  wire frameFall = frameSelND_r & ~frameSelNS;
  wire rxActive  = ~frameSelNS && bitCnt_r != `ASD_FRAME_BITS;

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      sclkD_r      <= 1'b0;
      frameSelND_r <= 1'b0; // synced pin reads low in reset: no false fall
    end else begin
      sclkD_r      <= sclkS;
      frameSelND_r <= frameSelNS;
    end
  end

  // extra clocks past sixteen are ignored until the next frame
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      bitCnt_r    <= `ASD_FRAME_BITS; // no capture until a frame starts
      rxShift_r   <= 16'h0;
      frameDone_r <= 1'b0;
    end else begin
      frameDone_r <= 1'b0;
      if (frameFall) begin
        bitCnt_r <= 5'h0;
      end else if (rxActive && sclkFall) begin
        rxShift_r <= {rxShift_r[14:0], sdiS};
        bitCnt_r  <= bitCnt_r + 5'h1;
        if (bitCnt_r == `ASD_FRAME_BITS - 5'h1) frameDone_r <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // dac write path; bus write wins if both arrive together
  // ----------------------------------------------------------------
  wire        busDacWr  = wrAck & selDacIn;
  wire        serDacWr  = frameDone_r & rxShift_r[`ASD_FRAME_DAC];
  wire        dacWrEn   = busDacWr | serDacWr;
  wire [2:0]  dacWrChan = busDacWr ? regChan : rxShift_r[14:12];
  wire [11:0] dacWrCode = busDacWr ? avs_writedata[11:0]
                                   : rxShift_r[11:0];

  // per-channel input and output registers
  for (genvar i = 0; i < 8; i++) begin : g_dac
    wire hit = dacWrEn && dacWrChan == 3'(i);
    always_ff @(posedge ref_clk) begin
      if (srst) begin
        dacIn_r[i]    <= 12'h000;
        dacWrStb_r[i] <= 1'b0;
        dacOut_r[i]   <= 12'h000;
      end else begin
        dacWrStb_r[i] <= hit;
        if (hit) dacIn_r[i] <= dacWrCode;
        if (loadAll_r || (dacWrStb_r[i] && !deferMode_r)) begin
          dacOut_r[i] <= dacIn_r[i];
        end
      end
    end
  end

  // straight binary codes go out unchanged
  assign dacCode = dacOut_r;

  // ----------------------------------------------------------------
  // conversion sequencer
  // ----------------------------------------------------------------
  wire [7:0] newMask  = avs_writedata[7:0] & adcMask_r;
  wire [7:0] liveMask = seqMask_r & adcMask_r;
  wire       timerEnd = timer_r == 8'h00;

  // a start during a running conversion is dropped; the host must wait
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      state_r       <= asd_pkg::SEQ_IDLE;
      seqMask_r     <= 8'h00;
      muxSel_r      <= 3'h0;
      convChan_r    <= 3'h0;
      timer_r       <= 8'h00;
      track_r       <= 1'b1;
      busy_r        <= 1'b1;
      result_r      <= 16'h0000;
      resultValid_r <= 1'b0;
    end else if (seqWr) begin
      seqMask_r     <= avs_writedata[7:0];
      muxSel_r      <= asdNextChan(newMask, 3'h0);
      track_r       <= 1'b1;
      resultValid_r <= 1'b0;
      state_r       <= |newMask ? asd_pkg::SEQ_TRACK : asd_pkg::SEQ_IDLE;
    end else begin
      unique case (state_r)
        asd_pkg::SEQ_IDLE: begin
          track_r <= 1'b1;
        end
        asd_pkg::SEQ_TRACK: begin
          // the host owns the 500 ns tracking time
          if (frameFall) begin
            state_r       <= asd_pkg::SEQ_CONVERT;
            convChan_r    <= muxSel_r;
            timer_r       <= 8'(`ASD_CONV_CYCLES - 1);
            track_r       <= 1'b0;
            busy_r        <= 1'b0;
            resultValid_r <= 1'b0;
          end
        end
        asd_pkg::SEQ_CONVERT: begin
          if (timerEnd) begin
            result_r      <= {1'b0, convChan_r, adcData};
            resultValid_r <= 1'b1;
            busy_r        <= 1'b1;
            track_r       <= 1'b1;
            muxSel_r      <= asdNextChan(liveMask, convChan_r + 3'h1);
            state_r       <= asd_pkg::SEQ_TRACK;
          end else begin
            timer_r <= timer_r - 8'h01;
          end
        end
      endcase
    end
  end

  assign muxSel    = muxSel_r;
  assign trackMode = track_r;

  // ----------------------------------------------------------------
  // serial transmit: previous result leaves during the next frame
  // ----------------------------------------------------------------
  // bits change on falling sclk so the host sees each one a full period
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      txShift_r <= 16'h0000;
    end else if (frameFall) begin
      txShift_r <= resultValid_r ? result_r : 16'h0000;
    end else if (rxActive && sclkFall) begin
      txShift_r <= {txShift_r[14:0], 1'b0};
    end
  end

  assign sdo = txShift_r[15];

  // ----------------------------------------------------------------
  // pin drive: dac and adc pins never carry gpo drive; busy on pin seven ignores the masks
  // ----------------------------------------------------------------
  for (genvar i = 0; i < 8; i++) begin : g_pin
    wire busyPin = busyEn_r && i == `ASD_BUSY_CHAN;
    wire digOut  = gpoMask_r[i] & ~dacMask_r[i] & ~adcMask_r[i];
    always_ff @(posedge ref_clk) begin
      if (srst) begin
        pinOut_r[i] <= 1'b0;
        pinOeN_r[i] <= 1'b1;
      end else begin
        pinOut_r[i] <= busyPin ? busy_r : gpoData_r[i];
        pinOeN_r[i] <= ~(busyPin | digOut);
      end
    end
  end

  assign pinOut = pinOut_r;
  assign pinOeN = pinOeN_r;

  // register writes during a conversion are not blocked; the host
  // keeps them out

endmodule : asd_ctrl

// File: asd_ctrl_checker.sv
`timescale 1ns/1ps
`include "asd_regs.svh"

// ----------------------------------------
// bus and sequencer checks
// ----------------------------------------
module asd_ctrl_checker (
  input wire logic        ref_clk,
  input wire logic        srst,
  input wire logic [7:0]  avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest,
  input wire logic [2:0]  muxSel,
  input wire logic        trackMode,
  input wire logic        adcRange,
  input wire logic        dacGain,
  input wire logic [7:0]  adcEnable
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (srst);

  logic [7:0] lowCnt_r;
  logic [7:0] seqMask_r;
  // a write lands at the edge where waitrequest is low
  wire       wrDone = avs_write && !avs_waitrequest;
  wire       gpWr   = wrDone && avs_address == `ASD_OFF_GP_CTRL;
  wire       seqWr  = wrDone && avs_address == `ASD_OFF_SEQ;
  wire [7:0] seqNew = avs_writedata[7:0] & adcEnable;
  wire [7:0] below  = (8'h01 << muxSel) - 8'h01;

  // hold length in a counter: 200 cycles is too long to unroll
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      lowCnt_r  <= 8'h00;
      seqMask_r <= 8'h00;
    end else begin
      lowCnt_r <= trackMode ? 8'h00 : lowCnt_r + 8'h01;
      if (seqWr)
        seqMask_r <= seqNew;
    end
  end

  sequence s_req;
    (avs_read || avs_write) && avs_waitrequest;
  endsequence
  sequence s_answer;
    !avs_waitrequest ##1 avs_waitrequest;
  endsequence

  a_wait_once: assert property (s_req |=> s_answer)
    else $error("waitrequest not low for one cycle");
  a_unmapped_zero: assert property (avs_read && !avs_waitrequest
    && avs_address >= 8'h68 |-> avs_readdata == 32'h0)
    else $error("unmapped read not zero");
  a_gain_follow: assert property (
    gpWr |=> dacGain == $past(avs_writedata[4]))
    else $error("dac gain not taken");
  a_range_follow: assert property (
    gpWr |=> adcRange == $past(avs_writedata[5]))
    else $error("adc range not taken");
  a_seq_first: assert property (
    seqWr && seqNew != 8'h00 |=> trackMode && seqMask_r[muxSel]
    && (seqMask_r & below) == 8'h00)
    else $error("first channel not tracking");
  a_hold_chan: assert property (
    $fell(trackMode) |-> seqMask_r[muxSel])
    else $error("hold on unselected channel");
  a_conv_time: assert property (
    $rose(trackMode) |-> lowCnt_r inside {[199:201]})
    else $error("conversion length wrong");
  a_conv_cap: assert property (lowCnt_r <= 8'd201)
    else $error("conversion overran");
  a_mux_frozen: assert property (
    !trackMode |=> trackMode || $stable(muxSel))
    else $error("mux moved during conversion");
  a_mux_next: assert property (
    $rose(trackMode) |-> seqMask_r[muxSel])
    else $error("mux not on a selected channel");
endmodule : asd_ctrl_checker

bind asd_ctrl asd_ctrl_checker chk (
  .ref_clk, .srst, .avs_address, .avs_read, .avs_write,
  .avs_writedata, .avs_readdata, .avs_waitrequest,
  .muxSel, .trackMode, .adcRange, .dacGain, .adcEnable
);

// File: asd_spi_host.sv
`timescale 1ns/1ps

// ----------------------------------------
// host end of the serial link
// ----------------------------------------
module asd_spi_host (
  output logic      sclk,
  output logic      frameSelN,
  output logic      sdi,
  input  wire logic sdo
);
  localparam int HALF = 80;

  // clock stands still low between frames
  initial begin
    sclk = 1'b0;
    frameSelN = 1'b1;
    sdi = 1'b0;
  end

  // one 16-bit frame, sdo taken mid-bit
  task automatic xfer(input logic [15:0] tx, output logic [15:0] rx);
    #603; // track time before each start, off the ref_clk edges
    frameSelN = 1'b0;
    for (int i = 15; i >= 0; i--) begin
      #HALF sclk = 1'b1;
      sdi = tx[i]; // set on the rise, steady across the fall
      rx[i] = sdo;
      #HALF sclk = 1'b0;
    end
    #HALF frameSelN = 1'b1;
    sdi = ~sdi; // released line must not look like the last bit
    #HALF;
  endtask : xfer
endmodule : asd_spi_host

// File: asd_ctrl_bench.sv
`timescale 1ns/1ps
`include "asd_regs.svh"

module asd_ctrl_bench;
  logic        ref_clk = 1'b0;
  logic        srst = 1'b1;
  logic [7:0]  avs_address = 8'h00;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic        sclk, frameSelN, sdi, sdo;
  logic [11:0] adcData = 12'h000;
  logic [7:0]  pinIn = 8'hFF;
  logic [2:0]  muxSel;
  logic        trackMode, adcRange, dacGain;
  logic [7:0]  dacEnable, adcEnable, pinOut, pinOeN;
  logic [95:0] dacCode;
  logic [15:0] rx;
  int          badCount = 0;
  int          nCompared = 0;
  int          cycles = 0;

  asd_ctrl dut (.ref_clk, .srst, .avs_address, .avs_read, .avs_write,
    .avs_writedata, .avs_readdata, .avs_waitrequest, .sclk, .frameSelN,
    .sdi, .sdo, .adcData, .muxSel, .trackMode, .adcRange, .dacGain,
    .dacEnable, .adcEnable, .dacCode, .pinIn, .pinOut, .pinOeN);
  asd_spi_host host (.sclk, .frameSelN, .sdi, .sdo);

  always #5 ref_clk = ~ref_clk;

  // a hang is cut short well beyond the expected run length
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 20000) begin
      badCount++;
      wrapUp();
    end
  end

  task automatic check(input string w, input logic [31:0] s,
                       input logic [31:0] e);
    nCompared++;
    if (s !== e) begin
      badCount++;
      $display("mismatch %s expected %h seen %h", w, e, s);
    end
  endtask : check

  // one avalon access; an extra edge keeps strobes from re-rising at once
  task automatic bus(input logic wr, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] q);
    avs_address   <= a;
    avs_writedata <= d;
    avs_write     <= wr;
    avs_read      <= !wr;
    do @(posedge ref_clk); while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
    @(posedge ref_clk);
  endtask : bus

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask : wr

  task automatic rdChk(input string w, input logic [7:0] a,
                       input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    check(w, q, e);
  endtask : rdChk

  task automatic testReset();
    rdChk("status", `ASD_OFF_STATUS, 32'h4);
    rdChk("unmapped", 8'hF0, 32'h0);
    check("oe", pinOeN, 8'hFF);
  endtask : testReset

  task automatic testPins();
    wr(`ASD_OFF_DAC_CFG, 32'h0B);
    wr(`ASD_OFF_ADC_CFG, 32'h05); // pin 0 both dac and adc
    wr(`ASD_OFF_GPO_CFG, 32'h30);
    wr(`ASD_OFF_GPO_DATA, 32'h10);
    check("dacEn", dacEnable, 8'h0B);
    check("adcEn", adcEnable, 8'h05);
    @(posedge ref_clk);
    check("gpo", {pinOeN[5:4], pinOut[5:4]}, 4'b0001);
    rdChk("gpi", `ASD_OFF_GPI_DATA, 32'hC0);
    wr(`ASD_OFF_GP_CTRL, 32'h10);
    check("gain", {dacGain, adcRange}, 2'b10);
    wr(`ASD_OFF_GP_CTRL, 32'h120); // busy on pin seven
    check("range", {dacGain, adcRange}, 2'b01);
    @(posedge ref_clk);
    check("busyIdle", {pinOeN[7], pinOut[7]}, 2'b01);
  endtask : testPins

  task automatic testDac();
    wr(8'h24, 32'hFFF);
    @(posedge ref_clk);
    check("dac1", dacCode[23:12], 12'hFFF);
    wr(`ASD_OFF_DEFER, 32'h1);
    wr(8'h20, 32'h800);
    @(posedge ref_clk);
    check("held", dacCode[11:0], 12'h000);
    wr(`ASD_OFF_DEFER, 32'h3);
    @(posedge ref_clk);
    check("load", dacCode[11:0], 12'h800);
    rdChk("out0", 8'h40, 32'h800);
    wr(`ASD_OFF_DEFER, 32'h0);
  endtask : testDac

  // serial dac write, then a frame whose top bit is clear
  task automatic testSerial();
    host.xfer(16'hB123, rx);
    repeat (8) @(posedge ref_clk);
    check("sdac", dacCode[47:36], 12'h123);
    host.xfer(16'h3456, rx);
    repeat (8) @(posedge ref_clk);
    check("ignored", dacCode[47:36], 12'h123);
  endtask : testSerial

  // ch1 is not an adc pin, so the sequence runs 0, 2, 0; writes stop
  task automatic testSeq();
    adcData <= 12'hABC;
    wr(`ASD_OFF_SEQ, 32'h07);
    check("first", {trackMode, muxSel}, 4'h8);
    fork
      host.xfer(16'h0000, rx);
      begin
        repeat (120) @(posedge ref_clk);
        check("hold", {trackMode, pinOut[7]}, 2'b00);
      end
    join
    check("rx1", rx, 16'h0000);
    check("next", {trackMode, muxSel, pinOut[7]}, 5'h15);
    @(posedge ref_clk);
    adcData <= 12'h555;
    host.xfer(16'h0000, rx);
    check("rx2", rx, 16'h0ABC);
    check("wrap", muxSel, 3'h0);
    host.xfer(16'h0000, rx);
    check("rx3", rx, 16'h2555);
  endtask : testSeq

  task automatic wrapUp();
    if (badCount == 0 && nCompared > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : wrapUp

  initial begin
    repeat (20) @(posedge ref_clk);
    srst <= 1'b0;
    @(posedge ref_clk);
    testReset();
    testPins();
    testDac();
    testSerial();
    testSeq();
    wrapUp();
  end
endmodule : asd_ctrl_bench
